// ==== scg_gate_sync.sv ====
`timescale 1ns/1ns
`default_nettype none
module scg_gate_sync
	import scg_pkg::*;
(
	input  wire logic                 pclk,
	input  wire logic                 presetn,
	input  wire logic [SCG_UNITS-1:0] want_on,
	output logic      [SCG_UNITS-1:0] gate_en
);
	// Enables change only from a flop on the clock's rising edge; the cell
	// downstream latches on the low phase, so the gated clock never glitches
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gate_en <= '0;
		end else begin
			gate_en <= want_on;
		end
	end
endmodule
`default_nettype wire

// ==== scg_pkg.sv ====
package scg_pkg;
	// Register offsets (byte addresses)
	localparam logic [11:0] SCG_SLEEP_GATE_OFF   = 12'h114;
	localparam logic [11:0] SCG_RUN_CFG_OFF      = 12'h060;
	localparam logic [11:0] SCG_INT_STATUS_OFF   = 12'h200;
	localparam logic [11:0] SCG_INT_MASK_OFF     = 12'h204;
	localparam logic [11:0] SCG_MODE_OFF         = 12'h208;
	// Sleep gating field positions
	localparam int SCG_CMP_ONE_BIT  = 25;
	localparam int SCG_CMP_ZERO_BIT = 24;
	localparam int SCG_TMR_TWO_BIT  = 18;
	localparam int SCG_TMR_ONE_BIT  = 17;
	localparam int SCG_TMR_ZERO_BIT = 16;
	localparam int SCG_TWI0_BIT     = 12;
	localparam int SCG_SYNC0_BIT    = 4;
	localparam int SCG_ASY1_BIT     = 1;
	localparam int SCG_ASY0_BIT     = 0;
	// Writable bits of the sleep gating register
	localparam logic [31:0] SCG_GATE_MASK  = 32'h03071013;
	localparam logic [31:0] SCG_GATE_RESET = 32'h00000000;
	// Run-mode clock configuration: automatic gating select position
	localparam int          SCG_AUTO_GATE_BIT = 27;
	localparam logic [31:0] SCG_RUN_CFG_RESET = 32'h00000000;
	// Interrupt status bits
	localparam int          SCG_IRQ_FAULT_BIT = 0;
	localparam int          SCG_IRQ_ENTER_BIT = 1;
	localparam int          SCG_IRQ_LEAVE_BIT = 2;
	localparam logic [31:0] SCG_IRQ_MASK_ALL  = 32'h00000007;
	localparam int          SCG_UNITS = 9;
	// Power mode encoding
	typedef enum logic [2:0] {
		SCG_RUN   = 3'b001,
		SCG_SLEEP = 3'b010,
		SCG_DEEP  = 3'b100
	} scg_mode_e;
endpackage

// ==== scg_sleep_gate.sv ====
`timescale 1ns/1ns
`default_nettype none
module scg_sleep_gate
	import scg_pkg::*;
(
	input  wire logic                 pclk,
	input  wire logic                 presetn,
	input  wire logic                 psel,
	input  wire logic                 penable,
	input  wire logic                 pwrite,
	input  wire logic [11:0]          paddr,
	input  wire logic [31:0]          pwdata,
	output logic      [31:0]          prdata,
	output logic                      pready,
	output logic                      pslverr,
	input  wire logic                 sleep_req,
	input  wire logic                 deep_sleep_req,
	input  wire logic                 wake_req,
	input  wire logic [31:0]          run_clock_gate_1,
	input  wire logic [31:0]          deep_sleep_clock_gate_1,
	input  wire logic [SCG_UNITS-1:0] unit_sel,
	input  wire logic                 unit_access,
	output logic                      unit_fault,
	output logic      [SCG_UNITS-1:0] unit_clk_en,
	output logic                      irq
);
	logic [31:0]          sleep_clock_gate_1;
	logic [31:0]          run_mode_clock_config;
	logic [31:0]          int_status;
	logic [31:0]          int_mask;
	scg_mode_e            mode;
	scg_mode_e            next_mode;
	logic [SCG_UNITS-1:0] want_on;
	logic [31:0]          active_gates;
	logic                 auto_gating_select;
	logic                 wr_go;
	logic                 rd_go;
	logic                 mode_enter;
	logic                 mode_leave;

	// Pick the nine controlled bits out of a gating word
	function automatic logic [SCG_UNITS-1:0] scg_pick(input logic [31:0] w);
		scg_pick = {w[SCG_CMP_ONE_BIT], w[SCG_CMP_ZERO_BIT], w[SCG_TMR_TWO_BIT],
			w[SCG_TMR_ONE_BIT], w[SCG_TMR_ZERO_BIT], w[SCG_TWI0_BIT],
			w[SCG_SYNC0_BIT], w[SCG_ASY1_BIT], w[SCG_ASY0_BIT]};
	endfunction

	// Zero-wait slave: every access completes in its first access cycle
	assign pready  = 1'b1;
	assign wr_go   = psel && penable && pwrite;
	assign rd_go   = psel && penable && !pwrite;
	assign auto_gating_select = run_mode_clock_config[SCG_AUTO_GATE_BIT];

	// Unmapped addresses answer with an error rather than silently succeed
	always_comb begin
		pslverr = 1'b0;
		if (psel && penable) begin
			unique case (paddr)
				SCG_SLEEP_GATE_OFF, SCG_RUN_CFG_OFF, SCG_INT_STATUS_OFF,
				SCG_INT_MASK_OFF, SCG_MODE_OFF: pslverr = 1'b0;
				default: pslverr = 1'b1;
			endcase
		end
	end

	// Sleep gating register; only documented enables are storable
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sleep_clock_gate_1 <= SCG_GATE_RESET;
		end else if (wr_go && paddr == SCG_SLEEP_GATE_OFF) begin
			sleep_clock_gate_1 <= pwdata & SCG_GATE_MASK;
		end
	end

	// Run-mode clock configuration, held here for its gating select bit
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			run_mode_clock_config <= SCG_RUN_CFG_RESET;
		end else if (wr_go && paddr == SCG_RUN_CFG_OFF) begin
			run_mode_clock_config <= pwdata;
		end
	end

	// Interrupt mask
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			int_mask <= '0;
		end else if (wr_go && paddr == SCG_INT_MASK_OFF) begin
			int_mask <= pwdata & SCG_IRQ_MASK_ALL;
		end
	end

	// Power mode sequencing; in run, deep sleep has priority over sleep and wake is ignored
	always_comb begin
		next_mode = mode;
		unique case (mode)
			SCG_RUN: begin
				if (deep_sleep_req) begin
					next_mode = SCG_DEEP;
				end else if (sleep_req) begin
					next_mode = SCG_SLEEP;
				end
			end
			SCG_SLEEP, SCG_DEEP: begin
				if (wake_req) begin
					next_mode = SCG_RUN;
				end
			end
			default: next_mode = SCG_RUN;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode <= SCG_RUN;
		end else begin
			mode <= next_mode;
		end
	end

	assign mode_enter = (mode == SCG_RUN) && (next_mode != SCG_RUN);
	assign mode_leave = (mode != SCG_RUN) && (next_mode == SCG_RUN);

	// Without automatic gating, sleep modes keep the run-mode enables
	always_comb begin
		active_gates = run_clock_gate_1;
		if (auto_gating_select) begin
			unique case (mode)
				SCG_SLEEP: active_gates = sleep_clock_gate_1;
				SCG_DEEP:  active_gates = deep_sleep_clock_gate_1;
				default:   active_gates = run_clock_gate_1;
			endcase
		end
	end

	assign want_on = scg_pick(active_gates);

	scg_gate_sync u_sync (
		.pclk    (pclk),
		.presetn (presetn),
		.want_on (want_on),
		.gate_en (unit_clk_en)
	);

	scg_unit_guard u_guard (
		.gate_en     (unit_clk_en),
		.unit_sel    (unit_sel),
		.unit_access (unit_access),
		.unit_fault  (unit_fault)
	);

	// Sticky events; a new event in the clearing cycle survives the clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			int_status <= '0;
		end else begin
			int_status <= (int_status
				& ~((wr_go && paddr == SCG_INT_STATUS_OFF) ? pwdata : 32'h00000000))
				| {29'h00000000, mode_leave, mode_enter, unit_fault};
		end
	end

	assign irq = (int_status & int_mask) != '0;

	// Read data registered; reserved gate bits come back as zero, run config reads back all 32 bits as written
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= '0;
		end else if (psel && !penable && !pwrite) begin
			unique case (paddr)
				SCG_SLEEP_GATE_OFF: prdata <= sleep_clock_gate_1;
				SCG_RUN_CFG_OFF:    prdata <= run_mode_clock_config;
				SCG_INT_STATUS_OFF: prdata <= int_status;
				SCG_INT_MASK_OFF:   prdata <= int_mask;
				SCG_MODE_OFF:       prdata <= {29'h00000000, mode};
				default:            prdata <= 32'h00000000;
			endcase
		end
	end
endmodule
`default_nettype wire

// ==== scg_sleep_gate_props.sv ====
`timescale 1ns/1ns
`default_nettype none
module scg_sleep_gate_props
	import scg_pkg::*;
(
	input wire logic                 pclk,
	input wire logic                 presetn,
	input wire logic                 psel,
	input wire logic                 penable,
	input wire logic                 pwrite,
	input wire logic [11:0]          paddr,
	input wire logic [31:0]          prdata,
	input wire logic                 pready,
	input wire logic                 pslverr,
	input wire logic                 sleep_req,
	input wire logic                 deep_sleep_req,
	input wire logic                 wake_req,
	input wire logic [31:0]          run_clock_gate_1,
	input wire logic [SCG_UNITS-1:0] unit_sel,
	input wire logic                 unit_access,
	input wire logic                 unit_fault,
	input wire logic [SCG_UNITS-1:0] unit_clk_en
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Access phase, and whether the address decodes to a register
	wire acc = psel && penable;
	wire hit = paddr inside {SCG_SLEEP_GATE_OFF, SCG_RUN_CFG_OFF, SCG_INT_STATUS_OFF,
		SCG_INT_MASK_OFF, SCG_MODE_OFF};
	wire [8:0] run_sel = {run_clock_gate_1[25:24], run_clock_gate_1[18:16],
		run_clock_gate_1[12], run_clock_gate_1[4], run_clock_gate_1[1:0]};
	// Wake held two cycles alone, so the mode is surely back to run
	sequence s_woke;
		(wake_req && !sleep_req && !deep_sleep_req) [*2];
	endsequence
	a_ready_high: assert property (pready)
		else $error("pready dropped");
	a_fault_gated: assert property (
		unit_fault == (unit_access && |(unit_sel & ~unit_clk_en)))
		else $error("unit fault does not match gated units");
	a_fault_idle: assert property (!unit_access |-> !unit_fault)
		else $error("unit fault without access");
	a_unmapped_err: assert property (acc && !hit |-> pslverr)
		else $error("unmapped access not refused");
	a_mapped_ok: assert property (acc && hit |-> !pslverr)
		else $error("mapped access refused");
	a_unmapped_zero: assert property (acc && !pwrite && !hit |-> prdata == 32'h0)
		else $error("unmapped read not zero");
	a_resv_zero: assert property (
		acc && !pwrite && paddr == SCG_SLEEP_GATE_OFF |-> (prdata & ~SCG_GATE_MASK) == 0)
		else $error("reserved gate bits read nonzero");
	a_wake_run: assert property (s_woke |=> unit_clk_en == $past(run_sel))
		else $error("run enables not applied after wake");
endmodule
`default_nettype wire

// ==== scg_unit_guard.sv ====
`timescale 1ns/1ns
`default_nettype none
module scg_unit_guard
	import scg_pkg::*;
(
	input  wire logic [SCG_UNITS-1:0] gate_en,
	input  wire logic [SCG_UNITS-1:0] unit_sel,
	input  wire logic                 unit_access,
	output logic                      unit_fault
);
	// Any access that selects an unclocked unit is refused with a fault
	assign unit_fault = unit_access && ((unit_sel & ~gate_en) != '0);
endmodule
`default_nettype wire

// ==== tb_top.sv ====
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin fail_count++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module tb_top;
	import scg_pkg::*;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er, irq;
	logic        sleep_req, deep_sleep_req, wake_req, unit_access, unit_fault;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd, run_w, deep_w, s;
	logic [8:0]  unit_sel, unit_clk_en, ex;
	int          fail_count, tests_run, cyc;
	scg_sleep_gate DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .sleep_req(sleep_req), .deep_sleep_req(deep_sleep_req),
		.wake_req(wake_req), .run_clock_gate_1(run_w), .deep_sleep_clock_gate_1(deep_w),
		.unit_sel(unit_sel), .unit_access(unit_access), .unit_fault(unit_fault),
		.unit_clk_en(unit_clk_en), .irq(irq));
	// Unit order of the enables, from the gate word's bit positions
	function automatic logic [8:0] sel(logic [31:0] r);
		return {r[25:24], r[18:16], r[12], r[4], r[1:0]};
	endfunction
	// One APB transfer; waits on pready rather than assuming a latency.
	// An idle edge after the release keeps psel from being driven twice at once
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 0; penable <= 0;
		@(posedge pclk);
	endtask
	// Requests held two cycles, then time for the gates to settle
	task go(input logic [2:0] k);
		{wake_req, deep_sleep_req, sleep_req} <= k;
		repeat (2) @(posedge pclk);
		{wake_req, deep_sleep_req, sleep_req} <= 3'b000;
		repeat (3) @(posedge pclk);
	endtask
	task final_report;
		$display("tests_run=%0d fail_count=%0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	initial begin
		pclk = 0;
		forever #20 pclk = ~pclk;
	end
	// Hang guard; the whole run needs well under a thousand cycles
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			fail_count++;
			final_report;
		end
	end
	initial begin
		void'($urandom(32'h8172D0D2));
		{presetn, psel, penable, pwrite, paddr, pwdata, sleep_req} = '0;
		{deep_sleep_req, wake_req, unit_access, unit_sel} = '0;
		run_w = $urandom; deep_w = $urandom;
		repeat (10) @(posedge pclk);
		presetn <= 1;
		@(posedge pclk);
		apb(0, SCG_SLEEP_GATE_OFF, 0); `CHK(rd, 32'h0)
		`CHK(unit_clk_en, sel(run_w))
		$display("reset test done");
		for (int i = 0; i < 10; i++) begin
			s = (i == 9) ? 32'hFFFFFFFF : $urandom;
			apb(1, SCG_SLEEP_GATE_OFF, s);
			apb(0, SCG_SLEEP_GATE_OFF, 0); `CHK(rd, s & SCG_GATE_MASK)
		end
		apb(1, 12'h100, 32'hFFFFFFFF);
		apb(0, 12'h100, 0); `CHK({er, rd}, {1'b1, 32'h0})
		$display("register test done");
		for (int a = 0; a < 2; a++) begin
			apb(1, SCG_RUN_CFG_OFF, 32'(a) << SCG_AUTO_GATE_BIT);
			apb(0, SCG_RUN_CFG_OFF, 0); `CHK(rd, 32'(a) << SCG_AUTO_GATE_BIT)
			s = $urandom;
			apb(1, SCG_SLEEP_GATE_OFF, s);
			go(3'b001);
			ex = a ? sel(s) : sel(run_w);
			`CHK(unit_clk_en, ex)
			apb(0, SCG_MODE_OFF, 0); `CHK(rd, {29'h00000000, SCG_SLEEP})
			unit_access <= 1; unit_sel <= ~ex;
			@(posedge pclk); `CHK(unit_fault, |(~ex))
			unit_sel <= 9'($urandom);
			@(posedge pclk); `CHK(unit_fault, |(unit_sel & ~ex))
			unit_access <= 0;
			go(3'b100); `CHK(unit_clk_en, sel(run_w))
		end
		go(3'b010); `CHK(unit_clk_en, sel(deep_w))
		go(3'b100);
		$display("gating test done");
		apb(1, SCG_INT_MASK_OFF, 0);
		@(posedge pclk); `CHK(irq, 1'b0)
		apb(1, SCG_INT_MASK_OFF, SCG_IRQ_MASK_ALL);
		@(posedge pclk); `CHK(irq, 1'b1)
		apb(0, SCG_INT_STATUS_OFF, 0); `CHK(rd, SCG_IRQ_MASK_ALL)
		apb(1, SCG_INT_STATUS_OFF, SCG_IRQ_MASK_ALL);
		apb(0, SCG_INT_STATUS_OFF, 0); `CHK(rd, 32'h0)
		`CHK(irq, 1'b0)
		$display("interrupt test done");
		// Reset again with enables and auto gating set, so a clear is visible
		apb(1, SCG_SLEEP_GATE_OFF, SCG_GATE_MASK);
		apb(1, SCG_RUN_CFG_OFF, 32'h00000001 << SCG_AUTO_GATE_BIT);
		presetn <= 0;
		repeat (2) @(posedge pclk);
		presetn <= 1;
		@(posedge pclk);
		apb(0, SCG_SLEEP_GATE_OFF, 0); `CHK(rd, 32'h0)
		apb(0, SCG_RUN_CFG_OFF, 0); `CHK(rd, 32'h0)
		`CHK(unit_clk_en, sel(run_w))
		`CHK(irq, 1'b0)
		$display("mid-run reset test done");
		final_report;
	end
endmodule
bind scg_sleep_gate scg_sleep_gate_props u_props (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .sleep_req(sleep_req), .wake_req(wake_req),
	.deep_sleep_req(deep_sleep_req), .run_clock_gate_1(run_clock_gate_1),
	.unit_sel(unit_sel), .unit_access(unit_access), .unit_fault(unit_fault),
	.unit_clk_en(unit_clk_en));
`default_nettype wire
